// ===== rtl/fractional_loop_pkg.sv
// constants and register layout for the fractional loop configuration block
package fractional_loop_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_LOOP_CONTROL   = 16'h0171;
   localparam logic [15:0] ADDR_UPDATE_INT     = 16'h0172;
   localparam logic [15:0] ADDR_FRAC_NUM       = 16'h0173;
   localparam logic [15:0] ADDR_FRAC_DEN       = 16'h0174;
   localparam logic [15:0] ADDR_RATIO_OUTDIV   = 16'h0175;
   localparam logic [15:0] ADDR_REF_DIVIDER    = 16'h0176;
   localparam logic [15:0] ADDR_SYNC_CONTROL   = 16'h0181;
   localparam logic [15:0] ADDR_SYNC_RATIO     = 16'h0185;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int LOOP_ENABLE_BIT   = 0;
   localparam int SYNC_ENABLE_BIT   = 0;
   localparam int APPLY_UPDATE_BIT  = 15;
   localparam int INT_MULT_MSB      = 9;
   localparam int INT_MULT_LSB      = 0;
   localparam int FB_RATIO_MSB      = 11;
   localparam int FB_RATIO_LSB      = 8;
   localparam int OUT_DIV_MSB       = 3;
   localparam int OUT_DIV_LSB       = 1;
   localparam int REF_DIV_MSB       = 7;
   localparam int REF_DIV_LSB       = 6;
   localparam int SYNC_RATIO_MSB    = 10;
   localparam int SYNC_RATIO_LSB    = 8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [9:0]  RST_INT_MULT    = 10'h008;
   localparam logic [15:0] RST_FRAC_NUM    = 16'h0018;
   localparam logic [15:0] RST_FRAC_DEN    = 16'h007d;
   localparam logic [3:0]  RST_FB_RATIO    = 4'h0;
   localparam logic [2:0]  RST_OUT_DIV     = 3'h2;
   localparam logic [1:0]  RST_REF_DIV     = 2'h0;
   localparam logic [2:0]  RST_SYNC_RATIO  = 3'h0;

   // ----------------------------------------------------------------
   // decode constants
   // ----------------------------------------------------------------
   localparam logic [2:0]  OUT_DIV_MIN_CODE   = 3'h2;
   localparam logic [2:0]  SYNC_RATIO_MAX_POW = 3'h4;
   localparam logic [16:0] SYNC_FRAC_SCALE    = 17'h10000;
endpackage : fractional_loop_pkg

// ===== rtl/fractional_loop_config.sv
// register file and divider decode for the fractional frequency-locked loop
`timescale 1ns/1ps
module fractional_loop_config
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [15:0] regAddr,
   input  wire logic [15:0] regWrData,
   output logic      [15:0] regRdData,
   output logic             regRdValid,
   output logic             loopEnable,
   output logic             syncPathEnable,
   output logic      [9:0]  activeIntMult,
   output logic      [15:0] activeFracNum,
   output logic      [16:0] fracDenominatorEff,
   output logic      [4:0]  feedbackDivide,
   output logic      [2:0]  outputDivide,
   output logic             outputDivReserved,
   output logic      [3:0]  referenceDivide,
   output logic      [4:0]  syncFeedbackDivide
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire logic wrCtrl   = regWrEn && (regAddr == fractional_loop_pkg::ADDR_LOOP_CONTROL);
   wire logic wrUpd    = regWrEn && (regAddr == fractional_loop_pkg::ADDR_UPDATE_INT);
   wire logic wrNum    = regWrEn && (regAddr == fractional_loop_pkg::ADDR_FRAC_NUM);
   wire logic wrDen    = regWrEn && (regAddr == fractional_loop_pkg::ADDR_FRAC_DEN);
   wire logic wrRatio  = regWrEn && (regAddr == fractional_loop_pkg::ADDR_RATIO_OUTDIV);
   wire logic wrRef    = regWrEn && (regAddr == fractional_loop_pkg::ADDR_REF_DIVIDER);
   wire logic wrSync   = regWrEn && (regAddr == fractional_loop_pkg::ADDR_SYNC_CONTROL);
   wire logic wrSyncR  = regWrEn && (regAddr == fractional_loop_pkg::ADDR_SYNC_RATIO);

   // write-data fields, named so each register update reads as one short line
   wire logic [9:0]  wrIntMult =
      regWrData[fractional_loop_pkg::INT_MULT_MSB:fractional_loop_pkg::INT_MULT_LSB];
   wire logic [3:0]  wrFbRatio =
      regWrData[fractional_loop_pkg::FB_RATIO_MSB:fractional_loop_pkg::FB_RATIO_LSB];
   wire logic [2:0]  wrOutDiv =
      regWrData[fractional_loop_pkg::OUT_DIV_MSB:fractional_loop_pkg::OUT_DIV_LSB];
   wire logic [1:0]  wrRefDiv =
      regWrData[fractional_loop_pkg::REF_DIV_MSB:fractional_loop_pkg::REF_DIV_LSB];
   wire logic [2:0]  wrSyncRatio =
      regWrData[fractional_loop_pkg::SYNC_RATIO_MSB:fractional_loop_pkg::SYNC_RATIO_LSB];

   // ----------------------------------------------------------------
   // software-visible registers
   // ----------------------------------------------------------------
   logic        enable_q;
   logic        syncEn_q;
   logic [9:0]  intMult_q;
   logic [15:0] fracNum_q;
   logic [15:0] fracDen_q;
   logic [3:0]  fbRatio_q;
   logic [2:0]  outDiv_q;
   logic [1:0]  refDiv_q;
   logic [2:0]  syncRatio_q;

   // next values of the pending copies, also used for a same-cycle apply
   wire logic [9:0]  intMult_d = wrUpd ? wrIntMult : intMult_q;
   wire logic [15:0] fracNum_d = wrNum ? regWrData : fracNum_q;

   // plain field storage; apply-update is not stored so it always reads zero
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enable_q    <= 1'b0;
         syncEn_q    <= 1'b0;
         intMult_q   <= fractional_loop_pkg::RST_INT_MULT;
         fracNum_q   <= fractional_loop_pkg::RST_FRAC_NUM;
         fracDen_q   <= fractional_loop_pkg::RST_FRAC_DEN;
         fbRatio_q   <= fractional_loop_pkg::RST_FB_RATIO;
         outDiv_q    <= fractional_loop_pkg::RST_OUT_DIV;
         refDiv_q    <= fractional_loop_pkg::RST_REF_DIV;
         syncRatio_q <= fractional_loop_pkg::RST_SYNC_RATIO;
      end
      else
      begin
         if (wrCtrl)
            enable_q <= regWrData[fractional_loop_pkg::LOOP_ENABLE_BIT];
         if (wrSync)
            syncEn_q <= regWrData[fractional_loop_pkg::SYNC_ENABLE_BIT];
         intMult_q <= intMult_d;
         fracNum_q <= fracNum_d;
         if (wrDen)
            fracDen_q <= regWrData;
         if (wrRatio)
         begin
            fbRatio_q <= wrFbRatio;
            outDiv_q  <= wrOutDiv;
         end
         if (wrRef)
            refDiv_q <= wrRefDiv;
         if (wrSyncR)
            syncRatio_q <= wrSyncRatio;
      end
   end

   // ----------------------------------------------------------------
   // active multiplier copy
   // ----------------------------------------------------------------
   // an apply only counts while the loop runs; when stopped the copy tracks anyway
   wire logic applyNow = wrUpd && regWrData[fractional_loop_pkg::APPLY_UPDATE_BIT]
                         && enable_q;
   wire logic tracking = !enable_q;

   // both values move in one edge, so the loop never sees a half-updated pair
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         activeIntMult <= fractional_loop_pkg::RST_INT_MULT;
         activeFracNum <= fractional_loop_pkg::RST_FRAC_NUM;
      end
      else if (applyNow || tracking)
      begin
         activeIntMult <= intMult_d;
         activeFracNum <= fracNum_d;
      end
   end

   // ----------------------------------------------------------------
   // divider decode
   // ----------------------------------------------------------------
   wire logic [4:0]  fbDiv_d   = {1'b0, fbRatio_q} + 5'h01;
   wire logic        outRes_d  = outDiv_q < fractional_loop_pkg::OUT_DIV_MIN_CODE;
   wire logic [3:0]  refDivN_d = 4'h1 << refDiv_q;
   // codes above four saturate at sixteen
   wire logic [2:0]  syncPow   = (syncRatio_q > fractional_loop_pkg::SYNC_RATIO_MAX_POW)
                                 ? fractional_loop_pkg::SYNC_RATIO_MAX_POW : syncRatio_q;
   wire logic [4:0]  syncDiv_d = 5'h01 << syncPow;
   // with sync on the stored denominator is ignored and the scale is fixed
   wire logic [16:0] denEff_d  = syncEn_q ? fractional_loop_pkg::SYNC_FRAC_SCALE
                                          : {1'b0, fracDen_q};

   // registered so every output comes from a flop
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         loopEnable         <= 1'b0;
         syncPathEnable     <= 1'b0;
         fracDenominatorEff <= {1'b0, fractional_loop_pkg::RST_FRAC_DEN};
         feedbackDivide     <= 5'h01;
         outputDivide       <= fractional_loop_pkg::RST_OUT_DIV;
         outputDivReserved  <= 1'b0;
         referenceDivide    <= 4'h1;
         syncFeedbackDivide <= 5'h01;
      end
      else
      begin
         loopEnable         <= enable_q;
         syncPathEnable     <= syncEn_q;
         fracDenominatorEff <= denEff_d;
         feedbackDivide     <= fbDiv_d;
         // a reserved code is flagged; the divider value passes unchanged
         outputDivide       <= outDiv_q;
         outputDivReserved  <= outRes_d;
         referenceDivide    <= refDivN_d;
         syncFeedbackDivide <= syncDiv_d;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [15:0] rdMux;
   // unmapped offsets and reserved bits read as zero
   always_comb
   begin
      rdMux = 16'h0000;
      case (regAddr)
         fractional_loop_pkg::ADDR_LOOP_CONTROL: rdMux = {15'h0000, enable_q};
         fractional_loop_pkg::ADDR_UPDATE_INT:   rdMux = {6'h00, intMult_q};
         fractional_loop_pkg::ADDR_FRAC_NUM:     rdMux = fracNum_q;
         fractional_loop_pkg::ADDR_FRAC_DEN:     rdMux = fracDen_q;
         fractional_loop_pkg::ADDR_RATIO_OUTDIV: rdMux = {4'h0, fbRatio_q, 4'h0, outDiv_q, 1'b0};
         fractional_loop_pkg::ADDR_REF_DIVIDER:  rdMux = {8'h00, refDiv_q, 6'h00};
         fractional_loop_pkg::ADDR_SYNC_CONTROL: rdMux = {15'h0000, syncEn_q};
         fractional_loop_pkg::ADDR_SYNC_RATIO:   rdMux = {5'h00, syncRatio_q, 8'h00};
         default:                                rdMux = 16'h0000;
      endcase
   end

   // read answers one cycle after the request
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         regRdData  <= 16'h0000;
         regRdValid <= 1'b0;
      end
      else
      begin
         regRdValid <= regRdEn;
         if (regRdEn)
            regRdData <= rdMux;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_hold_while_enabled;
      @(posedge clk_sys) disable iff (!reset_n)
      (enable_q && !applyNow) |=> $stable(activeIntMult) && $stable(activeFracNum);
   endproperty
   a_hold_while_enabled: assert property (p_hold_while_enabled)
      else $error("active multiplier changed without apply");

   property p_track_when_disabled;
      @(posedge clk_sys) disable iff (!reset_n)
      (!enable_q && wrNum) |=> (activeFracNum == $past(regWrData));
   endproperty
   a_track_when_disabled: assert property (p_track_when_disabled)
      else $error("numerator not effective while disabled");

   property p_apply_both;
      @(posedge clk_sys) disable iff (!reset_n)
      applyNow |=> (activeIntMult == intMult_q) && (activeFracNum == fracNum_q);
   endproperty
   a_apply_both: assert property (p_apply_both)
      else $error("apply did not transfer both values");

   property p_update_reads_zero;
      @(posedge clk_sys) disable iff (!reset_n)
      (regRdEn && regAddr == fractional_loop_pkg::ADDR_UPDATE_INT) |=> !regRdData[15];
   endproperty
   a_update_reads_zero: assert property (p_update_reads_zero)
      else $error("apply bit read back as one");

   property p_fb_divide;
      @(posedge clk_sys) disable iff (!reset_n)
      wrRatio |=> ##1 (feedbackDivide == {1'b0, $past(wrFbRatio, 2)} + 5'h01);
   endproperty
   a_fb_divide: assert property (p_fb_divide)
      else $error("feedback divide is not code plus one");

   property p_outdiv_reserved;
      @(posedge clk_sys) disable iff (!reset_n)
      outputDivReserved |-> (outputDivide < fractional_loop_pkg::OUT_DIV_MIN_CODE);
   endproperty
   a_outdiv_reserved: assert property (p_outdiv_reserved)
      else $error("reserved flag on a valid output divider");

   property p_ref_divide;
      @(posedge clk_sys) disable iff (!reset_n)
      wrRef |=> ##1 (referenceDivide == (4'h1 << $past(wrRefDiv, 2)));
   endproperty
   a_ref_divide: assert property (p_ref_divide)
      else $error("reference divide mismatch");

   property p_sync_divide;
      @(posedge clk_sys) disable iff (!reset_n)
      (syncRatio_q >= fractional_loop_pkg::SYNC_RATIO_MAX_POW) |=> (syncFeedbackDivide == 5'h10);
   endproperty
   a_sync_divide: assert property (p_sync_divide)
      else $error("sync divide not saturated at sixteen");

   property p_sync_den;
      @(posedge clk_sys) disable iff (!reset_n)
      syncEn_q |=> (fracDenominatorEff == fractional_loop_pkg::SYNC_FRAC_SCALE);
   endproperty
   a_sync_den: assert property (p_sync_den)
      else $error("denominator used while sync enabled");

   property p_int_track_when_disabled;
      @(posedge clk_sys) disable iff (!reset_n)
      (!enable_q && wrUpd) |=> (activeIntMult == $past(wrIntMult));
   endproperty
   a_int_track_when_disabled: assert property (p_int_track_when_disabled)
      else $error("multiplier not effective while disabled");

   c_apply: cover property (@(posedge clk_sys) disable iff (!reset_n) applyNow);
   c_pending: cover property (@(posedge clk_sys) disable iff (!reset_n)
      enable_q && wrUpd ##1 (intMult_q != activeIntMult));
   c_sync: cover property (@(posedge clk_sys) disable iff (!reset_n) syncEn_q && enable_q);
   c_tracking: cover property (@(posedge clk_sys) disable iff (!reset_n) !enable_q && wrNum);
   c_reserved: cover property (@(posedge clk_sys) disable iff (!reset_n) outputDivReserved);

endmodule : fractional_loop_config

// ===== verification/test_fractional_loop_config.sv
// self-checking testbench for the fractional loop configuration block
`timescale 1ns/1ps
module test_fractional_loop_config;
   // ----------------------------------------------------------------
   // stimulus and observation signals
   // ----------------------------------------------------------------
   logic        clk_sys;
   logic        reset_n;
   logic        regWrEn;
   logic        regRdEn;
   logic [15:0] regAddr;
   logic [15:0] regWrData;
   logic [15:0] regRdData;
   logic        regRdValid;
   logic        loopEnable;
   logic        syncPathEnable;
   logic [9:0]  activeIntMult;
   logic [15:0] activeFracNum;
   logic [16:0] fracDenominatorEff;
   logic [4:0]  feedbackDivide;
   logic [2:0]  outputDivide;
   logic        outputDivReserved;
   logic [3:0]  referenceDivide;
   logic [4:0]  syncFeedbackDivide;
   int          err_count;
   int          comparisons;
   logic [3:0]  code;

   fractional_loop_config dut_u (
      .clk_sys(clk_sys), .reset_n(reset_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .loopEnable(loopEnable), .syncPathEnable(syncPathEnable),
      .activeIntMult(activeIntMult), .activeFracNum(activeFracNum),
      .fracDenominatorEff(fracDenominatorEff), .feedbackDivide(feedbackDivide),
      .outputDivide(outputDivide), .outputDivReserved(outputDivReserved),
      .referenceDivide(referenceDivide), .syncFeedbackDivide(syncFeedbackDivide));

   // free-running system clock, 40 ns period
   always #20 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one write pulse, then an idle cycle so the strobe never re-rises in the same step
   task automatic wr(input logic [15:0] addr, input logic [15:0] data);
      regWrEn   = 1'b1;
      regAddr   = addr;
      regWrData = data;
      @(posedge clk_sys);
      #1;
      regWrEn = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : wr

   // read answer is due exactly one cycle after the request edge
   task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
      regRdEn = 1'b1;
      regAddr = addr;
      @(posedge clk_sys);
      #1;
      regRdEn = 1'b0;
      chk(17'(regRdValid), 17'h1);
      chk(17'(regRdData), 17'(exp));
      @(posedge clk_sys);
      #1;
      chk(17'(regRdValid), 17'h0);
   endtask : rd

   task automatic summarize();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // guard against a hung run
   initial
   begin
      #2000000;
      err_count++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0; reset_n = 1'b0; regWrEn = 1'b0; regRdEn = 1'b0;
      regAddr = 16'h0000; regWrData = 16'h0000; err_count = 0; comparisons = 0;
      repeat (4) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      chk(17'(activeIntMult), 17'h00008);
      chk(17'(activeFracNum), 17'h00018);
      chk(fracDenominatorEff, 17'h0007d);
      chk(17'({feedbackDivide, outputDivide, outputDivReserved}), 17'h00014);
      chk(17'({referenceDivide, syncFeedbackDivide, loopEnable}), 17'h00042);
      rd(fractional_loop_pkg::ADDR_LOOP_CONTROL, 16'h0000);
      rd(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h0008);
      rd(fractional_loop_pkg::ADDR_FRAC_NUM, 16'h0018);
      rd(fractional_loop_pkg::ADDR_FRAC_DEN, 16'h007d);
      rd(fractional_loop_pkg::ADDR_RATIO_OUTDIV, 16'h0004);
      rd(fractional_loop_pkg::ADDR_REF_DIVIDER, 16'h0000);
      rd(fractional_loop_pkg::ADDR_SYNC_RATIO, 16'h0000);
      $display("test reset_values done");
      // disabled loop: values go live without an apply write; reserved bits read zero
      wr(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h7d23);
      chk(17'(activeIntMult), 17'h00123);
      rd(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h0123);
      wr(fractional_loop_pkg::ADDR_FRAC_NUM, 16'h1234);
      chk(17'(activeFracNum), 17'h01234);
      $display("test direct_update done");
      // worked setting: 12 MHz reference, vco 98.304 MHz, N.K = 8.192 = 8 + 24/125
      wr(fractional_loop_pkg::ADDR_REF_DIVIDER, 16'h0000);
      wr(fractional_loop_pkg::ADDR_RATIO_OUTDIV, 16'h0008);
      wr(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h0008);
      wr(fractional_loop_pkg::ADDR_FRAC_NUM, 16'h0018);
      wr(fractional_loop_pkg::ADDR_FRAC_DEN, 16'h007d);
      chk(17'({outputDivide, referenceDivide, feedbackDivide}), 17'h00821);
      chk(17'({activeIntMult, activeFracNum[6:0]}), {10'h008, 7'h18});
      $display("test config_sequence done");
      // enabled loop: writes stay pending until the apply bit
      wr(fractional_loop_pkg::ADDR_LOOP_CONTROL, 16'h0001);
      chk(17'(loopEnable), 17'h1);
      wr(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h0055);
      wr(fractional_loop_pkg::ADDR_FRAC_NUM, 16'hffaa);
      chk({activeIntMult, activeFracNum[6:0]}, {10'h008, 7'h18});
      chk(17'(activeFracNum), 17'h00018);
      rd(fractional_loop_pkg::ADDR_FRAC_NUM, 16'hffaa);
      wr(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h8055);
      chk(17'(activeIntMult), 17'h00055);
      chk(17'(activeFracNum), 17'h0ffaa);
      rd(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h0055);
      wr(fractional_loop_pkg::ADDR_UPDATE_INT, 16'h83ff);
      chk(17'(activeIntMult), 17'h003ff);
      wr(fractional_loop_pkg::ADDR_LOOP_CONTROL, 16'h0000);
      chk(17'(loopEnable), 17'h0);
      $display("test pending_update done");
      // every ratio and divider code, reserved bits set on ratio and reference writes
      for (int i = 0; i < 16; i++)
      begin
         code = 4'(i);
         wr(fractional_loop_pkg::ADDR_RATIO_OUTDIV, {4'hf, code, 4'hf, code[2:0], 1'b1});
         chk(17'(feedbackDivide), 17'(i + 1));
         chk(17'(outputDivide), 17'(i % 8));
         chk(17'(outputDivReserved), 17'((i % 8) < 2));
         rd(fractional_loop_pkg::ADDR_RATIO_OUTDIV, {4'h0, code, 4'h0, code[2:0], 1'b0});
      end
      for (int i = 0; i < 4; i++)
      begin
         code = 4'(i);
         wr(fractional_loop_pkg::ADDR_REF_DIVIDER, {8'hff, code[1:0], 6'h3f});
         chk(17'(referenceDivide), 17'(1 << i));
         rd(fractional_loop_pkg::ADDR_REF_DIVIDER, {8'h00, code[1:0], 6'h00});
      end
      for (int i = 0; i < 8; i++)
      begin
         code = 4'(i);
         wr(fractional_loop_pkg::ADDR_SYNC_RATIO, {5'h00, code[2:0], 8'h00});
         chk(17'(syncFeedbackDivide), (i >= 4) ? 17'h10 : 17'(1 << i));
      end
      $display("test divider_codes done");
      // sync path: denominator replaced by the numerator scale
      wr(fractional_loop_pkg::ADDR_FRAC_DEN, 16'h0abc);
      chk(fracDenominatorEff, 17'h00abc);
      wr(fractional_loop_pkg::ADDR_SYNC_CONTROL, 16'h0001);
      chk(17'(syncPathEnable), 17'h1);
      chk(fracDenominatorEff, 17'h10000);
      // 48 kHz sync input: divide by 16, sync multiplier 98.304 MHz / 768 kHz = 128
      wr(fractional_loop_pkg::ADDR_SYNC_RATIO, 16'h0400);
      rd(fractional_loop_pkg::ADDR_SYNC_RATIO, 16'h0400);
      wr(fractional_loop_pkg::ADDR_FRAC_NUM, 16'h3127); // 0.192 x 65536
      wr(fractional_loop_pkg::ADDR_LOOP_CONTROL, 16'h0001);
      chk(17'({loopEnable, syncPathEnable, syncFeedbackDivide}), 17'h00070);
      chk(17'(activeFracNum), 17'h03127);
      rd(fractional_loop_pkg::ADDR_SYNC_CONTROL, 16'h0001);
      wr(fractional_loop_pkg::ADDR_LOOP_CONTROL, 16'h0000);
      wr(fractional_loop_pkg::ADDR_SYNC_CONTROL, 16'h0000);
      chk(fracDenominatorEff, 17'h00abc);
      // unmapped place: write ignored, read returns zero
      wr(16'h0177, 16'hffff);
      rd(16'h0177, 16'h0000);
      $display("test sync_and_unmapped done");
      summarize();
   end
endmodule : test_fractional_loop_config
